// ### verilog/acs_sequencer.sv
// Implementation choices: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ns
// What this block does
// - Mode zero, count zero: one conversion on go.
// - Start strobe three ADC clocks after go.
// - Done flag two bus, two ADC clocks after eoc.
// - Burst mode starts on trigger or software go.
// - Burst trigger is the one burst select names.
// - Burst converts configured slots back to back.
// - Count field holds conversions minus one.
// - Mode zero with nonzero count is sequential.
// - Sequential slot waits its own trigger.
// - Mode two with nonzero count is multiple.
// - Multiple mode: once go arms it, any selected trigger starts conversion.
// - Multiple mode serves armed triggers in arrival order.
// - Enable bit seven gates all conversions.
// - Restart bit six clear stops auto restart.
// - Bits sixteen to twelve set sampling time.
// - Software writes one to clear done flag.
// - Go bit clears itself next ADC clock.
// - Halt stops conversions, current one completes.
// - Trigger clear bit drops all trigger flags.
module acs_sequencer (
  // Clock and reset.
  input wire logic clock,
  input wire logic reset,
  // Avalon-MM slave.
  input wire logic [acs_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Trigger and converter pins.
  input wire logic [acs_pkg::N_TRIG-1:0] trig_evt,
  input wire logic conv_eoc,
  // Converter control.
  output logic conv_soc,
  output logic conv_sampling,
  output logic [2:0] conv_slot,
  output logic [4:0] conv_sample_time,
  output logic conv_enable
);
  import acs_pkg::*;

  acs_core_if link ();

  acs_trig_capture u_trig (.clock(clock), .reset(reset), .trig_evt(trig_evt), .link(link.trig));
  acs_eoc_timer u_eoc (.clock(clock), .reset(reset), .conv_eoc(conv_eoc), .link(link.eoc));

  acs_state_type state_q, state_d;
  acs_kind_type kind;
  logic [31:0] mode_q, mode_d, strg_q, strg_d, rdata_q, rdata_d;
  logic [3:0] btrg_q, btrg_d, div_q, div_d;
  logic [1:0] delay_q, delay_d;
  logic [4:0] samp_q, samp_d;
  logic [2:0] slot_q, slot_d, nconv_q, nconv_d, cnt, lt_q;
  logic [N_TRIG-1:0] take;
  logic [2:0] mq_q [N_SLOT];
  logic [2:0] mq_d [N_SLOT];
  logic [2:0] mq_wr_q, mq_wr_d, mq_rd_q, mq_rd_d;
  logic [3:0] mq_n_q, mq_n_d;
  logic [N_SLOT-1:0] queued_q, queued_d;
  logic tick_q, tick_d, wait_q, wait_d, go_q, go_d, halt_q, halt_d, clr_q, clr_d;
  logic done_q, done_d, seqf_q, seqf_d, armed_q, armed_d, soc_q, soc_d, smp_q, smp_d;
  logic en, rst_en, use_trig, stop, launch, pop, push, done_set, seq_set, last, acc_wr;
  logic [2:0] push_slot;
  logic [3:0] src_now;

  assign en = mode_q[MODE_EN_BIT];
  assign rst_en = mode_q[MODE_RST_BIT];
  assign cnt = mode_q[MODE_CNT_MSB:MODE_CNT_LSB];
  assign kind = acs_kind(mode_q[MODE_MOD_MSB:MODE_MOD_LSB], cnt);
  assign use_trig = mode_q[MODE_SRC_MSB:MODE_SRC_LSB] != SRC_SW_ONLY;
  assign stop = halt_q || !en;
  assign last = nconv_q == cnt;
  assign acc_wr = avs_write && !wait_q;
  assign link.take = take;
  assign link.clr_all = clr_q;
  assign link.adc_tick = tick_q;

  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;
  assign conv_soc = soc_q;
  assign conv_sampling = smp_q;
  assign conv_slot = slot_q;
  assign conv_sample_time = mode_q[MODE_ST_MSB:MODE_ST_LSB];
  assign conv_enable = mode_q[MODE_EN_BIT];

  // Bus slave: one wait state, read data sampled when the request is first seen.
  always_comb begin
    wait_d = !((avs_read || avs_write) && wait_q);
    rdata_d = rdata_q;
    mode_d = mode_q;
    btrg_d = btrg_q;
    strg_d = strg_q;
    clr_d = 1'b0;
    go_d = go_q && !tick_q && !launch;
    halt_d = halt_q && state_q != ST_IDLE;
    done_d = done_q;
    seqf_d = seqf_q;
    div_d = (div_q == ADC_DIV_LAST) ? 4'h0 : div_q + 4'h1;
    tick_d = div_q == ADC_DIV_LAST;
    if (avs_read && wait_q) begin
      rdata_d = '0;
      unique case (avs_address)
        OFS_MODE: rdata_d = mode_q;
        OFS_CTRL: begin
          rdata_d[CTRL_GO_BIT] = go_q;
          rdata_d[CTRL_HALT_BIT] = halt_q;
        end
        OFS_STAT: begin
          rdata_d[STAT_DONE_BIT] = done_q;
          rdata_d[STAT_SEQ_BIT] = seqf_q;
          rdata_d[STAT_BUSY_BIT] = state_q != ST_IDLE;
          rdata_d[STAT_PEND_LSB +: N_TRIG] = link.pend;
        end
        OFS_BTRG: rdata_d[BTRG_W-1:0] = btrg_q;
        OFS_STRG: rdata_d = strg_q;
        default: rdata_d = '0;
      endcase
    end
    if (acc_wr) begin
      unique case (avs_address)
        OFS_MODE: mode_d = be_merge(mode_q, avs_writedata, avs_byteenable) & MODE_WMASK;
        OFS_CTRL: begin
          if (avs_byteenable[0]) begin
            go_d = go_d || (avs_writedata[CTRL_GO_BIT] && en);
            clr_d = avs_writedata[CTRL_TCLR_BIT];
            halt_d = halt_d || avs_writedata[CTRL_HALT_BIT];
          end
        end
        OFS_STAT: begin
          if (avs_byteenable[0]) begin
            done_d = done_q && !avs_writedata[STAT_DONE_BIT];
            seqf_d = seqf_q && !avs_writedata[STAT_SEQ_BIT];
          end
        end
        OFS_BTRG: btrg_d = BTRG_W'(be_merge(32'(btrg_q), avs_writedata, avs_byteenable));
        OFS_STRG: strg_d = be_merge(strg_q, avs_writedata, avs_byteenable);
        default: ;
      endcase
    end
    done_d = done_d || done_set;
    seqf_d = seqf_d || seq_set;
  end

  // Conversion sequencer.
  always_comb begin
    state_d = state_q;
    delay_d = delay_q;
    samp_d = samp_q;
    slot_d = slot_q;
    nconv_d = nconv_q;
    armed_d = armed_q;
    soc_d = 1'b0;
    launch = 1'b0;
    pop = 1'b0;
    take = '0;
    done_set = 1'b0;
    seq_set = 1'b0;
    src_now = slot_src(strg_q, slot_q);
    if (go_q && kind == K_MULTI) begin
      armed_d = 1'b1;
    end
    if (stop) begin
      armed_d = 1'b0;
    end
    unique case (state_q)
      ST_IDLE: begin
        if (!stop) begin
          unique case (kind)
            K_SINGLE: launch = go_q;
            K_BURST: begin
              if (go_q) begin
                launch = 1'b1;
              end else if (use_trig && link.pend[btrg_q]) begin
                launch = 1'b1;
                take[btrg_q] = 1'b1;
              end
            end
            K_SEQ: begin
              if (go_q) begin
                launch = 1'b1;
              end else if (use_trig && link.pend[src_now]) begin
                launch = 1'b1;
                take[src_now] = 1'b1;
              end
            end
            K_MULTI: begin
              if (armed_q && mq_n_q != 4'h0) begin
                launch = 1'b1;
                pop = 1'b1;
                slot_d = mq_q[mq_rd_q];
                take[slot_src(strg_q, mq_q[mq_rd_q])] = 1'b1;
              end
            end
            K_NONE: ;
          endcase
        end
        if (launch) begin
          state_d = ST_DELAY;
          delay_d = '0;
        end
      end
      ST_DELAY: begin
        if (stop) begin
          state_d = ST_IDLE;
          slot_d = '0;
          nconv_d = '0;
        end else if (tick_q) begin
          if (delay_q == SOC_TICKS_LAST) begin
            soc_d = 1'b1;
            state_d = ST_SAMPLE;
            samp_d = '0;
          end else begin
            delay_d = delay_q + 2'h1;
          end
        end
      end
      ST_SAMPLE: begin
        if (tick_q) begin
          if (samp_q == mode_q[MODE_ST_MSB:MODE_ST_LSB]) begin
            state_d = ST_CONVERT;
          end else begin
            samp_d = samp_q + 5'h01;
          end
        end
      end
      ST_CONVERT: begin
        if (link.eoc_done) begin
          done_set = 1'b1;
          if (stop || last) begin
            nconv_d = '0;
            slot_d = '0;
            seq_set = last;
            if (last && !rst_en) begin
              armed_d = 1'b0;
            end
            if (!stop && last && rst_en && (kind == K_SINGLE || kind == K_BURST)) begin
              state_d = ST_DELAY;
              delay_d = '0;
            end else begin
              state_d = ST_IDLE;
            end
          end else begin
            nconv_d = nconv_q + 3'h1;
            slot_d = slot_q + 3'h1;
            state_d = (kind == K_BURST) ? ST_DELAY : ST_IDLE;
            delay_d = '0;
          end
        end
      end
    endcase
    smp_d = state_d == ST_SAMPLE;
  end

  // Arrival queue for multiple mode: lowest slot first among same-cycle arrivals.
  always_comb begin
    mq_d = mq_q;
    mq_wr_d = mq_wr_q;
    mq_rd_d = mq_rd_q;
    queued_d = queued_q;
    push = 1'b0;
    push_slot = '0;
    if (kind == K_MULTI && armed_q && use_trig) begin
      for (int k = 0; k < N_SLOT; k++) begin
        if (!push && 3'(k) <= cnt && !queued_q[k] && link.pend[slot_src(strg_q, 3'(k))] &&
            !take[slot_src(strg_q, 3'(k))]) begin
          push = 1'b1;
          push_slot = 3'(k);
        end
      end
    end
    if (pop) begin
      mq_rd_d = mq_rd_q + 3'h1;
      queued_d[mq_q[mq_rd_q]] = 1'b0;
    end
    if (push) begin
      mq_d[mq_wr_q] = push_slot;
      mq_wr_d = mq_wr_q + 3'h1;
      queued_d[push_slot] = 1'b1;
    end
    mq_n_d = mq_n_q + {3'h0, push} - {3'h0, pop};
    if (!(kind == K_MULTI && armed_q)) begin
      mq_wr_d = '0;
      mq_rd_d = '0;
      mq_n_d = '0;
      queued_d = '0;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      wait_q <= 1'b1;
      rdata_q <= '0;
      mode_q <= MODE_RESET;
      btrg_q <= '0;
      strg_q <= '0;
      clr_q <= 1'b0;
      go_q <= 1'b0;
      halt_q <= 1'b0;
      done_q <= 1'b0;
      seqf_q <= 1'b0;
      div_q <= '0;
      tick_q <= 1'b0;
      state_q <= ST_IDLE;
      delay_q <= '0;
      samp_q <= '0;
      slot_q <= '0;
      nconv_q <= '0;
      armed_q <= 1'b0;
      soc_q <= 1'b0;
      smp_q <= 1'b0;
      mq_q <= '{default: '0};
      mq_wr_q <= '0;
      mq_rd_q <= '0;
      mq_n_q <= '0;
      queued_q <= '0;
    end else begin
      wait_q <= wait_d;
      rdata_q <= rdata_d;
      mode_q <= mode_d;
      btrg_q <= btrg_d;
      strg_q <= strg_d;
      clr_q <= clr_d;
      go_q <= go_d;
      halt_q <= halt_d;
      done_q <= done_d;
      seqf_q <= seqf_d;
      div_q <= div_d;
      tick_q <= tick_d;
      state_q <= state_d;
      delay_q <= delay_d;
      samp_q <= samp_d;
      slot_q <= slot_d;
      nconv_q <= nconv_d;
      armed_q <= armed_d;
      soc_q <= soc_d;
      smp_q <= smp_d;
      mq_q <= mq_d;
      mq_wr_q <= mq_wr_d;
      mq_rd_q <= mq_rd_d;
      mq_n_q <= mq_n_d;
      queued_q <= queued_d;
    end
  end

  // Checking helper: ADC clocks since the start delay began, saturating.
  // A burst chain or an automatic restart enters the delay without a launch, so count from the state change.
  always_ff @(posedge clock) begin
    if (reset || (state_d == ST_DELAY && state_q != ST_DELAY)) begin
      lt_q <= '0;
    end else if (tick_q && lt_q != 3'h7) begin
      lt_q <= lt_q + 3'h1;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  property p_soc_delay;
    $rose(soc_q) && state_q == ST_SAMPLE |-> lt_q == SOC_TICKS && $past(state_q) == ST_DELAY;
  endproperty
  a_soc_delay: assert property (p_soc_delay) else $error("start strobe not three adc clocks after start");

  property p_single_go;
    state_q == ST_IDLE && kind == K_SINGLE && go_q && !stop |=> state_q == ST_DELAY ##1 !go_q;
  endproperty
  a_single_go: assert property (p_single_go) else $error("single mode did not start on go");

  property p_go_clear;
    go_q && tick_q && !(acc_wr && avs_address == OFS_CTRL) |=> !go_q;
  endproperty
  a_go_clear: assert property (p_go_clear) else $error("go bit not cleared at adc clock");

  property p_block_en;
    state_q == ST_IDLE && !en |=> state_q == ST_IDLE;
  endproperty
  a_block_en: assert property (p_block_en) else $error("conversion launched while disabled");

  property p_halt;
    halt_q && state_q == ST_DELAY |=> state_q == ST_IDLE && !soc_q;
  endproperty
  a_halt: assert property (p_halt) else $error("halt did not abort pending start");

  property p_burst_chain;
    state_q == ST_CONVERT && link.eoc_done && kind == K_BURST && !last && !stop |=> state_q == ST_DELAY;
  endproperty
  a_burst_chain: assert property (p_burst_chain) else $error("burst did not chain next conversion");

  property p_count;
    state_q != ST_IDLE |-> nconv_q <= cnt;
  endproperty
  a_count: assert property (p_count) else $error("conversion count beyond field");

  property p_done_set;
    state_q == ST_CONVERT && link.eoc_done |=> done_q;
  endproperty
  a_done_set: assert property (p_done_set) else $error("done flag not set at end of conversion");

  property p_done_clear;
    acc_wr && avs_address == OFS_STAT && avs_byteenable[0] && avs_writedata[STAT_DONE_BIT] && !done_set |=> !done_q;
  endproperty
  a_done_clear: assert property (p_done_clear) else $error("write one did not clear done flag");

  property p_no_restart;
    state_q == ST_CONVERT && link.eoc_done && last && !rst_en |=> state_q == ST_IDLE;
  endproperty
  a_no_restart: assert property (p_no_restart) else $error("restarted with restart bit clear");

  c_single: cover property (kind == K_SINGLE && soc_q ##[1:200] done_q);
  c_burst_seq: cover property (kind == K_BURST && seq_set && cnt == 3'h7);
  c_multi: cover property (kind == K_MULTI && pop ##[1:300] pop);

endmodule // acs_sequencer

// ### verilog/acs_pkg.sv
package acs_pkg;

  // Register map and field layout.
  localparam int ADDR_W = 5;
  localparam int N_TRIG = 16;
  localparam int N_SLOT = 8;
  localparam logic [4:0] OFS_MODE = 5'h00;
  localparam logic [4:0] OFS_CTRL = 5'h04;
  localparam logic [4:0] OFS_STAT = 5'h08;
  localparam logic [4:0] OFS_BTRG = 5'h0C;
  localparam logic [4:0] OFS_STRG = 5'h10;
  localparam int MODE_SRC_LSB = 0;
  localparam int MODE_SRC_MSB = 1;
  localparam int MODE_MOD_LSB = 4;
  localparam int MODE_MOD_MSB = 5;
  localparam int MODE_RST_BIT = 6;
  localparam int MODE_EN_BIT = 7;
  localparam int MODE_CNT_LSB = 8;
  localparam int MODE_CNT_MSB = 10;
  localparam int MODE_ST_LSB = 12;
  localparam int MODE_ST_MSB = 16;
  localparam logic [31:0] MODE_WMASK = 32'h0001_F7F3;
  localparam logic [31:0] MODE_RESET = 32'h0000_0000;
  localparam int CTRL_GO_BIT = 0;
  localparam int CTRL_TCLR_BIT = 1;
  localparam int CTRL_HALT_BIT = 7;
  localparam int STAT_DONE_BIT = 0;
  localparam int STAT_SEQ_BIT = 2;
  localparam int STAT_BUSY_BIT = 8;
  localparam int STAT_PEND_LSB = 16;
  localparam int BTRG_W = 4;

  // Field codes.
  localparam logic [1:0] MOD_SEQ = 2'h0;
  localparam logic [1:0] MOD_BURST = 2'h1;
  localparam logic [1:0] MOD_MULTI = 2'h2;
  localparam logic [1:0] SRC_SW_ONLY = 2'h0;
  localparam logic [2:0] CNT_ZERO = 3'h0;

  // Timing: the ADC clock is the bus clock divided by two (ADC_DIV_LAST plus one).
  localparam logic [3:0] ADC_DIV_LAST = 4'h1;
  localparam logic [1:0] SOC_TICKS_LAST = 2'h2;
  localparam logic [2:0] SOC_TICKS = 3'h3;
  localparam logic [1:0] EOC_PCLK_LAST = 2'h1;
  localparam logic [1:0] EOC_ADC_LAST = 2'h1;

  typedef enum logic [2:0] {K_NONE, K_SINGLE, K_BURST, K_SEQ, K_MULTI} acs_kind_type;
  typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_SAMPLE, ST_CONVERT} acs_state_type;
  typedef enum logic [1:0] {E_IDLE, E_PCLK, E_ADC} acs_eoc_state_type;

  function automatic acs_kind_type acs_kind(input logic [1:0] m, input logic [2:0] c);
    if (m == MOD_SEQ) begin
      acs_kind = (c == CNT_ZERO) ? K_SINGLE : K_SEQ;
    end else if (m == MOD_BURST) begin
      acs_kind = K_BURST;
    end else if (m == MOD_MULTI && c != CNT_ZERO) begin
      acs_kind = K_MULTI;
    end else begin
      acs_kind = K_NONE;
    end
  endfunction

  function automatic logic [31:0] be_merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] be);
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        o[b*8 +: 8] = n[b*8 +: 8];
      end
    end
    be_merge = o;
  endfunction

  function automatic logic [3:0] slot_src(input logic [31:0] s, input logic [2:0] idx);
    slot_src = s[int'(idx)*BTRG_W +: BTRG_W];
  endfunction

endpackage

// ### verilog/acs_core_if.sv
`timescale 1ns/1ns
interface acs_core_if;
  logic [acs_pkg::N_TRIG-1:0] pend;
  logic [acs_pkg::N_TRIG-1:0] take;
  logic clr_all;
  logic adc_tick;
  logic eoc_done;
  modport trig (output pend, input take, input clr_all);
  modport eoc (input adc_tick, output eoc_done);
  modport ctrl (input pend, output take, output clr_all, output adc_tick, input eoc_done);
endinterface

// ### verilog/acs_trig_capture.sv
`timescale 1ns/1ns
module acs_trig_capture (
  // Clock and reset.
  input wire logic clock,
  input wire logic reset,
  // Trigger event pins.
  input wire logic [acs_pkg::N_TRIG-1:0] trig_evt,
  // Sequencer side.
  acs_core_if.trig link
);
  import acs_pkg::*;

  logic [N_TRIG-1:0] s1_q, s2_q, s3_q, pend_q, pend_d, rise;

  assign rise = s2_q & ~s3_q;
  assign link.pend = pend_q;

  // A new edge wins over a take or a clear in the same cycle.
  always_comb begin
    pend_d = link.clr_all ? '0 : (pend_q & ~link.take);
    pend_d = pend_d | rise;
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      pend_q <= '0;
    end else begin
      s1_q <= trig_evt;
      s2_q <= s1_q;
      s3_q <= s2_q;
      pend_q <= pend_d;
    end
  end

  property p_trig_clear;
    @(posedge clock) disable iff (reset) link.clr_all && rise == '0 |=> pend_q == '0;
  endproperty
  a_trig_clear: assert property (p_trig_clear) else $error("trigger flags survived a clear");

endmodule // acs_trig_capture

// ### verilog/acs_eoc_timer.sv
`timescale 1ns/1ns
module acs_eoc_timer (
  // Clock and reset.
  input wire logic clock,
  input wire logic reset,
  // End-of-conversion pin from the converter core.
  input wire logic conv_eoc,
  // Sequencer side.
  acs_core_if.eoc link
);
  import acs_pkg::*;

  acs_eoc_state_type st_q, st_d;
  logic [1:0] cnt_q, cnt_d;
  logic s1_q, s2_q, s3_q, done_q, done_d, rise;

  assign rise = s2_q & ~s3_q;
  assign link.eoc_done = done_q;

  // Two bus clocks, then two ADC clocks, then the done pulse.
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    done_d = 1'b0;
    unique case (st_q)
      E_IDLE: begin
        if (rise) begin
          st_d = E_PCLK;
          cnt_d = '0;
        end
      end
      E_PCLK: begin
        if (cnt_q == EOC_PCLK_LAST) begin
          st_d = E_ADC;
          cnt_d = '0;
        end else begin
          cnt_d = cnt_q + 2'h1;
        end
      end
      E_ADC: begin
        if (link.adc_tick) begin
          if (cnt_q == EOC_ADC_LAST) begin
            st_d = E_IDLE;
            done_d = 1'b1;
          end else begin
            cnt_d = cnt_q + 2'h1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      st_q <= E_IDLE;
      cnt_q <= '0;
      done_q <= 1'b0;
    end else begin
      s1_q <= conv_eoc;
      s2_q <= s1_q;
      s3_q <= s2_q;
      st_q <= st_d;
      cnt_q <= cnt_d;
      done_q <= done_d;
    end
  end

  property p_eoc_pclk;
    @(posedge clock) disable iff (reset) rise && st_q == E_IDLE |=> st_q == E_PCLK [*2] ##1 st_q == E_ADC;
  endproperty
  a_eoc_pclk: assert property (p_eoc_pclk) else $error("bus clock phase of eoc delay wrong");

  property p_eoc_adc;
    @(posedge clock) disable iff (reset) done_q |-> $past(st_q) == E_ADC && $past(link.adc_tick);
  endproperty
  a_eoc_adc: assert property (p_eoc_adc) else $error("eoc done not after adc phase");

endmodule // acs_eoc_timer

// ### dv/acs_conv_model.sv
`timescale 1ns/1ns
module acs_conv_model (
  // Clock and reset.
  input wire logic clock,
  input wire logic reset,
  // Converter core side.
  input wire logic conv_sampling,
  input wire logic slow,
  output logic conv_eoc,
  // Trigger sources.
  input wire logic [15:0] trig_fire,
  output logic [15:0] trig_evt
);
  logic samp_q;
  logic [15:0] d1_q;
  logic [15:0] d2_q;
  logic [15:0] d3_q;
  int cnt_q;
  int hi_q;

  // Timer and PWM events stay high four cycles so the sync stage sees them.
  assign trig_evt = trig_fire | d1_q | d2_q | d3_q;
  assign conv_eoc = (hi_q != 0);

  // The core ends conversion a while after sampling closes, quickly or slowly.
  always_ff @(posedge clock) begin
    if (reset) begin
      samp_q <= 1'b0;
      cnt_q <= 0;
      hi_q <= 0;
      d1_q <= '0;
      d2_q <= '0;
      d3_q <= '0;
    end else begin
      samp_q <= conv_sampling;
      d1_q <= trig_fire;
      d2_q <= d1_q;
      d3_q <= d2_q;
      if (samp_q && !conv_sampling) begin
        cnt_q <= slow ? 12 : 2;
      end else if (cnt_q > 0) begin
        cnt_q <= cnt_q - 1;
      end
      if (cnt_q == 1) begin
        hi_q <= 3;
      end else if (hi_q > 0) begin
        hi_q <= hi_q - 1;
      end
    end
  end
endmodule // acs_conv_model

// ### dv/acs_sequencer_tb.sv
`timescale 1ns/1ns
module acs_sequencer_tb;
  import acs_pkg::*;
  logic clock, reset, avs_read, avs_write, avs_waitrequest, conv_eoc, conv_soc, slow, conv_sampling, conv_enable;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, v;
  logic [15:0] trig_evt, trig_fire;
  logic [2:0] conv_slot;
  logic [4:0] conv_sample_time;
  logic [2:0] slot_log [$];
  int err_total, checks, cyc, soc_n, eoc_n, soc_cyc, eoc_cyc, wr_cyc, rd_cyc, g;
  logic eoc_d;

  acs_sequencer acs_sequencer_inst (.clock(clock), .reset(reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .trig_evt(trig_evt),
    .conv_eoc(conv_eoc), .conv_soc(conv_soc), .conv_sampling(conv_sampling), .conv_slot(conv_slot),
    .conv_sample_time(conv_sample_time), .conv_enable(conv_enable));
  acs_conv_model acs_conv_model_inst (.clock(clock), .reset(reset),
    .conv_sampling(conv_sampling), .slow(slow), .conv_eoc(conv_eoc),
    .trig_fire(trig_fire), .trig_evt(trig_evt));

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  always @(posedge clock) begin
    cyc <= cyc + 1;
    eoc_d <= conv_eoc;
    if (conv_soc === 1'b1) begin
      soc_n++;
      soc_cyc = cyc;
      slot_log.push_back(conv_slot);
    end
    if (conv_eoc === 1'b1 && eoc_d !== 1'b1) begin
      eoc_n++;
      eoc_cyc = cyc;
    end
    if (cyc > 30000) begin
      err_total++;
      end_sim();
    end
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic bus_wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    do @(posedge clock); while (avs_waitrequest !== 1'b0);
    wr_cyc = cyc;
    avs_write <= 1'b0;
  endtask

  task automatic bus_rd(input logic [4:0] a, output logic [31:0] d);
    @(posedge clock);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge clock); while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    rd_cyc = cyc;
    avs_read <= 1'b0;
  endtask

  task automatic fire(input int n);
    @(posedge clock);
    trig_fire <= 16'h1 << n;
    @(posedge clock);
    trig_fire <= '0;
  endtask

  task automatic wait_flag(input int b);
    v = '0;
    for (int i = 0; i < 300 && v[b] !== 1'b1; i++) bus_rd(OFS_STAT, v);
    chk("status flag", 32'(v[b]), 32'h1);
  endtask

  task automatic fresh(input logic [31:0] mode);
    bus_wr(OFS_MODE, 32'h0);
    bus_wr(OFS_STAT, 32'h5);
    bus_wr(OFS_CTRL, 32'h2);
    bus_wr(OFS_MODE, mode);
    soc_n = 0;
    eoc_n = 0;
    slot_log.delete();
  endtask

  task automatic end_sim();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    {avs_address, avs_read, avs_write, avs_writedata, trig_fire, slow} = '0;
    {err_total, checks, cyc, soc_n, eoc_n, soc_cyc, eoc_cyc, wr_cyc, rd_cyc} = '0;
    reset = 1'b1;
    repeat (8) @(posedge clock);
    reset <= 1'b0;
    repeat (4) @(posedge clock);
    bus_rd(OFS_MODE, v);
    chk("mode reset", v, MODE_RESET);
    bus_wr(5'h14, 32'hFFFF_FFFF);
    bus_rd(5'h14, v);
    chk("unmapped", v, 32'h0);
    bus_wr(OFS_MODE, 32'hFFFF_FFFF);
    bus_rd(OFS_MODE, v);
    chk("mode mask", v, MODE_WMASK);
    fresh(32'h0);
    bus_wr(OFS_CTRL, 32'h1);
    repeat (30) @(posedge clock);
    chk("go while off", soc_n, 0);
    $display("test registers done");
    fresh(32'h0000_3080);
    @(posedge clock);
    chk("sample time", 32'(conv_sample_time), 32'h3);
    chk("enable pin", 32'(conv_enable), 32'h1);
    bus_wr(OFS_CTRL, 32'h1);
    g = wr_cyc;
    bus_rd(OFS_CTRL, v);
    chk("go self clear", 32'(v[0]), 32'h0);
    wait_flag(STAT_DONE_BIT);
    chk("single count", soc_n, 1);
    chk("soc delay", 32'(soc_cyc - g >= 5 && soc_cyc - g <= 8), 32'h1);
    chk("done delay", 32'(rd_cyc - eoc_cyc >= 7 && rd_cyc - eoc_cyc <= 14), 32'h1);
    bus_wr(OFS_STAT, 32'h1);
    bus_rd(OFS_STAT, v);
    chk("done clear", 32'(v[0]), 32'h0);
    $display("test single done");
    slow = 1'b1;
    fresh(32'h0000_0790);
    bus_wr(OFS_CTRL, 32'h1);
    wait_flag(STAT_SEQ_BIT);
    repeat (80) @(posedge clock);
    chk("burst count", soc_n, 8);
    chk("last slot", 32'(slot_log[7]), 32'h7);
    $display("test burst done");
    bus_wr(OFS_BTRG, 32'h5);
    fresh(32'h0000_0191);
    fire(3);
    repeat (40) @(posedge clock);
    chk("other trigger", soc_n, 0);
    bus_rd(OFS_STAT, v);
    chk("pending seen", 32'(v[STAT_PEND_LSB + 3]), 32'h1);
    fire(5);
    wait_flag(STAT_SEQ_BIT);
    chk("burst trigger", soc_n, 2);
    bus_wr(OFS_CTRL, 32'h2);
    bus_rd(OFS_STAT, v);
    chk("trigger clear", 32'(v[31:16]), 32'h0);
    $display("test burst trigger done");
    bus_wr(OFS_STRG, 32'h0000_0076);
    fresh(32'h0000_0181);
    fire(7);
    repeat (40) @(posedge clock);
    chk("slot waits", soc_n, 0);
    fire(6);
    wait_flag(STAT_SEQ_BIT);
    chk("slot zero first", 32'(slot_log[0]), 32'h0);
    chk("slot one next", 32'(slot_log[1]), 32'h1);
    chk("seq count", soc_n, 2);
    $display("test sequential done");
    bus_wr(OFS_STRG, 32'h0000_0492);
    fresh(32'h0000_02A1);
    bus_wr(OFS_CTRL, 32'h1);
    fire(4);
    fire(9);
    fire(2);
    repeat (200) @(posedge clock);
    chk("multi count", soc_n, 3);
    chk("order first", 32'(slot_log[0]), 32'h2);
    chk("order second", 32'(slot_log[1]), 32'h1);
    chk("order third", 32'(slot_log[2]), 32'h0);
    $display("test multiple done");
    fresh(32'h0000_00C0);
    bus_wr(OFS_CTRL, 32'h1);
    for (int i = 0; i < 300 && soc_n < 2; i++) @(posedge clock);
    chk("auto restart", 32'(soc_n >= 2), 32'h1);
    bus_wr(OFS_CTRL, 32'h80);
    g = soc_n;
    repeat (200) @(posedge clock);
    chk("halt stops", 32'(soc_n - g <= 1), 32'h1);
    chk("halt completes", eoc_n, soc_n);
    bus_rd(OFS_STAT, v);
    chk("idle after halt", 32'(v[STAT_BUSY_BIT]), 32'h0);
    $display("test halt done");
    end_sim();
  end
endmodule // acs_sequencer_tb
